/* uimc_pkg.sv */
package uimc_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_ENABLE   = 3'h1;
  localparam logic [2:0] OFS_IDENT    = 3'h2;
  localparam logic [2:0] OFS_HCTRL    = 3'h4;
  localparam logic [2:0] OFS_LSTAT    = 3'h5;
  localparam logic [2:0] OFS_HSTAT    = 3'h6;
  localparam logic [2:0] OFS_RXBUF    = 3'h0;
  localparam logic [2:0] OFS_TXHOLD   = 3'h0;
  // Reset values
  localparam logic [3:0] RST_ENABLE   = 4'h0;
  localparam logic [4:0] RST_HCTRL    = 5'h00;
  localparam logic [5:0] RST_LSTAT    = 6'h20;
  localparam logic [3:0] RST_HDELTA   = 4'h0;
  // Identification codes on bits 2..0
  localparam logic [2:0] ID_NONE      = 3'h1;
  localparam logic [2:0] ID_LINE      = 3'h6;
  localparam logic [2:0] ID_RXDATA    = 3'h4;
  localparam logic [2:0] ID_TXEMPTY   = 3'h2;
  localparam logic [2:0] ID_HSTAT     = 3'h0;
  // Enable bit positions
  localparam int EN_RX   = 0;
  localparam int EN_TX   = 1;
  localparam int EN_LINE = 2;
  localparam int EN_HS   = 3;
  // Handshake control bit positions
  localparam int HC_DTR  = 0;
  localparam int HC_RTS  = 1;
  localparam int HC_AUX1 = 2;
  localparam int HC_AUX2 = 3;
  localparam int HC_LOOP = 4;
  // Line status bit positions
  localparam int LS_READY = 0;
  localparam int LS_THE   = 5;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uimc_bus_s;

  // Handshake lines as seen at the pins (active low)
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ring_n;
    logic carrier_detect_input_n;
  } uimc_hs_in_s;

  typedef struct packed {
    logic dtr_n;
    logic rts_n;
    logic aux1_n;
    logic aux2_n;
  } uimc_hs_out_s;

  // Line status event pulses from receiver and transmitter
  typedef struct packed {
    logic rx_ready;
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic brk;
    logic tx_moved;
  } uimc_ls_ev_s;

  typedef enum logic [1:0] {
    UIMC_IDLE   = 2'b01,
    UIMC_FROZEN = 2'b10
  } uimc_id_e;
endpackage

/* uimc_core.sv */
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Reading the identification register freezes the top pending source, unless it is transmit empty, until serviced.
// - Identification bit 0 reads 0 when pending, code 001 when nothing pending.
// - Identification bits 3 to 7 read zero.
// - Line status interrupt is top priority, code 110, cleared by reading line status.
// - Received data interrupt second, code 100, cleared by reading receive buffer.
// - Transmit empty third, code 010, cleared by identification read or holding write.
// - Handshake status lowest, code 000, raised by input change, cleared by status read.
// - Enable bits 0..3 select received, transmit, line and handshake; bits 4..7 zero.
// - All enables clear suppresses identification and output; status still updates.
// - Control bits 0..3 drive active-low dtr, rts, aux1, aux2 pins inverted.
// - Loop bit marks serial output, feeds transmit data back, loops handshake lines.
// - In loopback, handshake interrupts come from control bits 0..3, still enabled.
// - Software writes to low six line and low four handshake bits set them.
// - Control bits 5 to 7 read zero.
// - Status bits 0,1,3 set on change of cts, dsr, carrier since last read.
// - Status bit 2 set only on ring falling from on to off.
// - Reading handshake status clears all four change bits.
// - Any change bit set raises the handshake status interrupt.
// - Status bits 4..7 are complemented inputs, or rts, dtr, aux1, aux2 in loopback.
// - Overrun, parity, framing, break in line bits 1..4 raise line interrupt.
// - Transmit-empty flag sets on holding-to-shift move, clears on holding write.
module uimc_core
  import uimc_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // Register port
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [2:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  output logic      [7:0]             o_rdata,
  // Receiver and transmitter events
  input  uimc_pkg::uimc_ls_ev_s       i_ls_ev,
  input  wire logic                   i_tx_shift_out,
  output logic                        o_rx_serial,
  // Serial pins
  input  wire logic                   i_serial_input,
  output logic                        o_serial_output,
  // Handshake pins
  input  uimc_pkg::uimc_hs_in_s       i_hs,
  output uimc_pkg::uimc_hs_out_s      o_hs,
  // Status to framing logic
  output logic                        o_loop,
  output logic                        o_interrupt_output
);
  import uimc_pkg::*;

  logic        rst_s1_r;
  logic        rst_n_r;
  uimc_bus_s   bus;
  logic [3:0]  enable_r;
  logic [4:0]  hctrl_r;
  logic [5:0]  lstat_r;
  logic [3:0]  hdelta_r;
  logic [3:0]  hs_cur;
  logic [3:0]  hs_prev_r;
  logic        hs_valid_r;
  logic        transmit_holding_empty_irq_r;
  logic [2:0]  frozen_id_r;
  uimc_id_e    id_state_r;
  logic [2:0]  live_id;
  logic [2:0]  shown_id;
  logic        p_line;
  logic        p_rx;
  logic        p_tx;
  logic        p_hs;
  logic        rd_ident;
  logic        rd_lstat;
  logic        rd_hstat;
  logic        rd_rxbuf;
  logic        wr_tx;
  logic        frz_serviced;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  assign bus.wr    = i_wr;
  assign bus.rd    = i_rd;
  assign bus.addr  = i_addr;
  assign bus.wdata = i_wdata;

  function automatic logic hit(input uimc_bus_s b, input logic is_rd, input logic [2:0] ofs);
    hit = (is_rd ? b.rd : b.wr) && (b.addr == ofs);
  endfunction

  assign rd_ident = hit(bus, 1'b1, OFS_IDENT);
  assign rd_lstat = hit(bus, 1'b1, OFS_LSTAT);
  assign rd_hstat = hit(bus, 1'b1, OFS_HSTAT);
  assign rd_rxbuf = hit(bus, 1'b1, OFS_RXBUF);
  assign wr_tx    = hit(bus, 1'b0, OFS_TXHOLD);

  assign o_loop = hctrl_r[HC_LOOP];

  // Handshake pins and serial routing
  always_comb begin
    o_hs.dtr_n      = ~hctrl_r[HC_DTR];
    o_hs.rts_n      = ~hctrl_r[HC_RTS];
    o_hs.aux1_n     = ~hctrl_r[HC_AUX1];
    o_hs.aux2_n     = ~hctrl_r[HC_AUX2];
    o_serial_output = hctrl_r[HC_LOOP] ? 1'b1 : i_tx_shift_out;
    o_rx_serial     = hctrl_r[HC_LOOP] ? i_tx_shift_out : i_serial_input;
  end

  // Current handshake levels, order cts, dsr, ring, carrier (active high)
  always_comb begin
    if (hctrl_r[HC_LOOP]) begin
      hs_cur = {hctrl_r[HC_AUX2], hctrl_r[HC_AUX1],
                hctrl_r[HC_DTR], hctrl_r[HC_RTS]};
    end else begin
      hs_cur = {~i_hs.carrier_detect_input_n, ~i_hs.ring_n,
                ~i_hs.dsr_n, ~i_hs.cts_n};
    end
  end

  // Enable register
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      enable_r <= RST_ENABLE;
    end else if (hit(bus, 1'b0, OFS_ENABLE)) begin
      enable_r <= bus.wdata[3:0];
    end
  end

  // Handshake control register
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hctrl_r <= RST_HCTRL;
    end else if (hit(bus, 1'b0, OFS_HCTRL)) begin
      hctrl_r <= bus.wdata[4:0];
    end
  end

  // Line status flags; hardware events win over the read clear
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lstat_r <= RST_LSTAT;
    end else begin
      if (hit(bus, 1'b0, OFS_LSTAT)) begin
        lstat_r <= bus.wdata[5:0];
      end else begin
        if (rd_lstat) begin
          lstat_r[4:1] <= 4'h0;
        end
        if (rd_rxbuf) begin
          lstat_r[LS_READY] <= 1'b0;
        end
        if (wr_tx) begin
          lstat_r[LS_THE] <= 1'b0;
        end
        if (i_ls_ev.rx_ready) begin
          lstat_r[LS_READY] <= 1'b1;
        end
        if (i_ls_ev.overrun) begin
          lstat_r[1] <= 1'b1;
        end
        if (i_ls_ev.parity_err) begin
          lstat_r[2] <= 1'b1;
        end
        if (i_ls_ev.framing_err) begin
          lstat_r[3] <= 1'b1;
        end
        if (i_ls_ev.brk) begin
          lstat_r[4] <= 1'b1;
        end
        if (i_ls_ev.tx_moved) begin
          lstat_r[LS_THE] <= 1'b1;
        end
      end
    end
  end

  // Transmit-empty interrupt: separate from the flag so an ident read can drop it
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      transmit_holding_empty_irq_r <= 1'b0;
    end else if (i_ls_ev.tx_moved
                 || (hit(bus, 1'b0, OFS_LSTAT) && bus.wdata[LS_THE])) begin
      transmit_holding_empty_irq_r <= 1'b1;
    end else if (wr_tx || (rd_ident && shown_id == ID_TXEMPTY)) begin
      transmit_holding_empty_irq_r <= 1'b0;
    end
  end

  // Previous handshake levels; first sample after reset is not a change
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hs_prev_r  <= 4'h0;
      hs_valid_r <= 1'b0;
    end else begin
      hs_prev_r  <= hs_cur;
      hs_valid_r <= 1'b1;
    end
  end

  // Change bits: set wins over the read clear
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hdelta_r <= RST_HDELTA;
    end else if (hit(bus, 1'b0, OFS_HSTAT)) begin
      hdelta_r <= bus.wdata[3:0];
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (hs_valid_r && ((k == 2) ? (hs_prev_r[k] && !hs_cur[k])
                                    : (hs_prev_r[k] != hs_cur[k]))) begin
          hdelta_r[k] <= 1'b1;
        end else if (rd_hstat) begin
          hdelta_r[k] <= 1'b0;
        end
      end
    end
  end

  // Pending sources gated by enables
  assign p_line = enable_r[EN_LINE] && |lstat_r[4:1];
  assign p_rx   = enable_r[EN_RX]   && lstat_r[LS_READY];
  assign p_tx   = enable_r[EN_TX]   && transmit_holding_empty_irq_r;
  assign p_hs   = enable_r[EN_HS]   && |hdelta_r;

  always_comb begin
    if (p_line) begin
      live_id = ID_LINE;
    end else if (p_rx) begin
      live_id = ID_RXDATA;
    end else if (p_tx) begin
      live_id = ID_TXEMPTY;
    end else if (p_hs) begin
      live_id = ID_HSTAT;
    end else begin
      live_id = ID_NONE;
    end
  end

  // Frozen source is serviced once its own pending term drops
  always_comb begin
    case (frozen_id_r)
      ID_LINE:    frz_serviced = !p_line;
      ID_RXDATA:  frz_serviced = !p_rx;
      ID_TXEMPTY: frz_serviced = !p_tx;
      ID_HSTAT:   frz_serviced = !p_hs;
      default:    frz_serviced = 1'b1;
    endcase
  end

  // A serviced source no longer masks the live code, even before the state drops
  assign shown_id = (id_state_r == UIMC_FROZEN && !frz_serviced) ? frozen_id_r
                                                                  : live_id;

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      id_state_r  <= UIMC_IDLE;
      frozen_id_r <= ID_NONE;
    end else begin
      case (id_state_r)
        UIMC_IDLE: begin
          if (rd_ident && live_id != ID_NONE && live_id != ID_TXEMPTY) begin
            id_state_r  <= UIMC_FROZEN;
            frozen_id_r <= live_id;
          end
        end
        UIMC_FROZEN: begin
          if (frz_serviced) begin
            if (rd_ident && live_id != ID_NONE && live_id != ID_TXEMPTY) begin
              frozen_id_r <= live_id;
            end else begin
              id_state_r  <= UIMC_IDLE;
              frozen_id_r <= ID_NONE;
            end
          end
        end
        default: begin
          id_state_r  <= UIMC_IDLE;
          frozen_id_r <= ID_NONE;
        end
      endcase
    end
  end

  // Interrupt output
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_interrupt_output <= 1'b0;
    end else begin
      o_interrupt_output <= p_line || p_rx || p_tx || p_hs;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_ENABLE: o_rdata <= {4'h0, enable_r};
        OFS_IDENT:  o_rdata <= {5'h00, shown_id};
        OFS_HCTRL:  o_rdata <= {3'h0, hctrl_r};
        OFS_LSTAT:  o_rdata <= {2'h0, lstat_r};
        OFS_HSTAT:  o_rdata <= {hs_cur, hdelta_r};
        default:    o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

/* uimc_core_chk.sv */
`timescale 1ns/1ps
module uimc_core_chk
  import uimc_pkg::*;
(
  // Clock, reset and register port
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [2:0]        i_addr,
  input wire logic [7:0]        i_wdata,
  input wire logic [7:0]        o_rdata,
  // Serial and handshake pins
  input wire logic              i_tx_shift_out,
  input wire logic              i_serial_input,
  input wire logic              o_rx_serial,
  input wire logic              o_serial_output,
  input uimc_pkg::uimc_hs_in_s  i_hs,
  input uimc_pkg::uimc_hs_out_s o_hs,
  input wire logic              o_loop,
  input wire logic              o_interrupt_output
);
  import uimc_pkg::*;
  logic [3:0] en_m_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Enable shadow, so gating can be judged from the pins alone
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_m_r <= 4'h0;
    end else if (i_wr && i_addr == OFS_ENABLE) begin
      en_m_r <= i_wdata[3:0];
    end
  end
  sequence s_calm;
    !o_loop && $stable(i_hs);
  endsequence
  a_ident_upper_zero: assert property (
    i_rd && i_addr == OFS_IDENT |=> o_rdata[7:3] == 5'h00) else $error("ident high bits set");
  a_ctrl_upper_zero: assert property (
    i_rd && i_addr == OFS_HCTRL |=> o_rdata[7:5] == 3'h0) else $error("control high bits set");
  a_enable_readback: assert property (
    i_rd && i_addr == OFS_ENABLE |=> o_rdata == {4'h0, en_m_r}) else $error("enable readback");
  a_pins_follow_ctrl: assert property (i_wr && i_addr == OFS_HCTRL |=>
    o_hs == ~{$past(i_wdata[0]), $past(i_wdata[1]), $past(i_wdata[2]), $past(i_wdata[3])})
    else $error("handshake outputs wrong");
  a_loop_bit_set: assert property (
    i_wr && i_addr == OFS_HCTRL |=> o_loop == $past(i_wdata[4])) else $error("loop bit");
  a_loop_marks: assert property (
    o_loop |-> o_serial_output && o_rx_serial == i_tx_shift_out) else $error("loop routing");
  a_rx_from_pin: assert property (
    !o_loop |-> o_rx_serial == i_serial_input) else $error("serial input routing");
  a_quiet_disabled: assert property (
    $past(en_m_r) == 4'h0 && $past(en_m_r, 2) == 4'h0 |-> !o_interrupt_output)
    else $error("interrupt with enables clear");
  a_ident_disabled: assert property (
    i_rd && i_addr == OFS_IDENT && en_m_r == 4'h0 && $past(en_m_r) == 4'h0
    |=> o_rdata == {5'h00, ID_NONE}) else $error("ident not idle with enables clear");
  a_pending_bit: assert property (
    i_rd && i_addr == OFS_IDENT |=> o_rdata[0] == !o_interrupt_output)
    else $error("pending bit disagrees with interrupt");
  a_status_levels: assert property (s_calm [*4] ##0 (i_rd && i_addr == OFS_HSTAT) |=>
    o_rdata[7:4] == ~{$past(i_hs.carrier_detect_input_n), $past(i_hs.ring_n),
    $past(i_hs.dsr_n), $past(i_hs.cts_n)}) else $error("status levels wrong");
  c_irq_rise: cover property ($rose(o_interrupt_output));
  c_loop_read: cover property (o_loop && i_rd && i_addr == OFS_HSTAT);
  c_ident_live: cover property (i_rd && i_addr == OFS_IDENT && en_m_r != 4'h0);
endmodule
bind uimc_core uimc_core_chk chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_tx_shift_out(i_tx_shift_out),
  .i_serial_input(i_serial_input), .o_rx_serial(o_rx_serial), .o_serial_output(o_serial_output),
  .i_hs(i_hs), .o_hs(o_hs), .o_loop(o_loop), .o_interrupt_output(o_interrupt_output));

/* uimc_modem.sv */
`timescale 1ns/1ps
module uimc_modem
  import uimc_pkg::*;
(
  // Clock and block outputs
  input wire logic              i_clk,
  input uimc_pkg::uimc_hs_out_s i_hs,
  // Test controls
  input wire logic              i_slow,
  input wire logic [1:0]        i_line_n,
  // Lines back to the block
  output uimc_pkg::uimc_hs_in_s o_hs
);
  import uimc_pkg::*;
  logic [1:0] ans_r;
  logic [1:0] ans2_r;
  // Answers request-to-send with clear-to-send, terminal-ready with set-ready
  always_ff @(posedge i_clk) begin
    ans_r <= {i_hs.rts_n, i_hs.dtr_n};
    ans2_r <= ans_r;
  end
  assign o_hs = {i_slow ? ans2_r : ans_r, i_line_n};
endmodule

/* test_uart_interrupt_modem_control.sv */
`timescale 1ns/1ps
module test_uart_interrupt_modem_control;
  import uimc_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_nrst = 1'b0;
  logic         i_wr = 1'b0;
  logic         i_rd = 1'b0;
  logic         i_slow = 1'b0;
  logic         i_serial_input = 1'b0;
  logic         i_tx_shift_out = 1'b0;
  logic [2:0]   i_addr = 3'h0;
  logic [7:0]   i_wdata = 8'h00;
  logic [1:0]   line_n = 2'h3;
  uimc_ls_ev_s  i_ls_ev = '0;
  logic [7:0]   o_rdata;
  logic         o_rx_serial;
  logic         o_serial_output;
  logic         o_loop;
  logic         o_interrupt_output;
  uimc_hs_in_s  i_hs;
  uimc_hs_out_s o_hs;
  logic [7:0]   rv;
  logic [7:0]   v;
  logic [7:0]   xp;
  logic [3:0]   eff;
  logic [3:0]   prev;
  int           fails = 0;
  int           n_checks = 0;
  int           cyc = 0;

  always #2 i_clk = ~i_clk;

  uimc_core dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_ls_ev(i_ls_ev), .i_tx_shift_out(i_tx_shift_out),
    .o_rx_serial(o_rx_serial), .i_serial_input(i_serial_input),
    .o_serial_output(o_serial_output), .i_hs(i_hs), .o_hs(o_hs), .o_loop(o_loop),
    .o_interrupt_output(o_interrupt_output));
  uimc_modem modem_u (.i_clk(i_clk), .i_hs(o_hs), .i_slow(i_slow), .i_line_n(line_n),
    .o_hs(i_hs));

  always @(posedge i_clk) begin
    i_serial_input <= 1'($urandom);
    i_tx_shift_out <= 1'($urandom);
    cyc++;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
    @(posedge i_clk);
    chk(rv, exp);
  endtask
  task automatic ev(input int k);
    i_ls_ev <= 6'h01 << k;
    @(posedge i_clk);
    i_ls_ev <= '0;
    @(posedge i_clk);
  endtask
  // Status byte from old and new asserted levels {cd, ring, dsr, cts}
  function automatic logic [7:0] hs_exp(input logic [3:0] p, input logic [3:0] e);
    return {e, p[3] ^ e[3], p[2] & ~e[2], p[1] ^ e[1], p[0] ^ e[0]};
  endfunction

  initial begin
    void'($urandom(63));
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({4'h0, o_hs}, 8'h0F);
    rd(OFS_ENABLE, 8'h00);
    rd(OFS_IDENT, 8'h01);
    rd(OFS_LSTAT, 8'h20);
    rd(OFS_HSTAT, 8'h00);
    wr(OFS_IDENT, 8'hFF);
    rd(OFS_IDENT, 8'h01);
    rd(3'h7, 8'h00);
    wr(OFS_ENABLE, 8'hF8);
    rd(OFS_ENABLE, 8'h08);
    prev = 4'h0;
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom) & 8'hEF;
      wr(OFS_HCTRL, v);
      line_n <= 2'($urandom);
      i_slow <= 1'($urandom);
      repeat (6) @(posedge i_clk);
      eff = {~line_n[0], ~line_n[1], v[0], v[1]};
      xp = hs_exp(prev, eff);
      chk({4'h0, o_hs}, {4'h0, ~v[0], ~v[1], ~v[2], ~v[3]});
      chk({7'h00, o_interrupt_output}, {7'h00, |xp[3:0]});
      rd(OFS_HCTRL, v & 8'h1F);
      rd(OFS_IDENT, (|xp[3:0]) ? {5'h00, ID_HSTAT} : {5'h00, ID_NONE});
      rd(OFS_HSTAT, xp);
      rd(OFS_HSTAT, {eff, 4'h0});
      chk({7'h00, o_interrupt_output}, 8'h00);
      prev = eff;
    end
    wr(OFS_HCTRL, 8'h14);
    #1;
    chk({6'h00, o_serial_output, o_rx_serial ^ i_tx_shift_out}, 8'h02);
    @(posedge i_clk);
    rd(OFS_HSTAT, hs_exp(prev, 4'h4));
    wr(OFS_HCTRL, 8'h10);
    rd(OFS_HSTAT, 8'h04);
    wr(OFS_HCTRL, 8'h1B);
    rd(OFS_HSTAT, 8'hBB);
    // Enables cleared before the loop bit is dropped, change bits cleared after
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_HCTRL, 8'h00);
    line_n <= 2'h3;
    repeat (6) @(posedge i_clk);
    wr(OFS_HSTAT, 8'h00);
    wr(OFS_ENABLE, 8'h0F);
    wr(OFS_LSTAT, 8'h3F);
    rd(OFS_IDENT, 8'h06);
    rd(OFS_LSTAT, 8'h3F);
    rd(OFS_IDENT, 8'h04);
    rd(OFS_RXBUF, 8'h00);
    rd(OFS_IDENT, 8'h02);
    rd(OFS_IDENT, 8'h01);
    ev(0);
    rd(OFS_IDENT, 8'h02);
    wr(OFS_TXHOLD, 8'h5A);
    rd(OFS_IDENT, 8'h01);
    rd(OFS_LSTAT, 8'h00);
    for (int k = 1; k < 5; k++) begin
      ev(5 - k);
      rd(OFS_IDENT, 8'h06);
      rd(OFS_LSTAT, 8'(8'h01 << k));
      rd(OFS_IDENT, 8'h01);
    end
    wr(OFS_HSTAT, 8'h01);
    rd(OFS_IDENT, 8'h00);
    ev(5);
    rd(OFS_IDENT, 8'h00);
    rd(OFS_HSTAT, 8'h01);
    rd(OFS_IDENT, 8'h04);
    rd(OFS_RXBUF, 8'h00);
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_LSTAT, 8'h02);
    rd(OFS_IDENT, 8'h01);
    chk({7'h00, o_interrupt_output}, 8'h00);
    rd(OFS_LSTAT, 8'h02);
    give_verdict();
  end
endmodule
